// [bench/sppm_checker_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module sppm_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Link side
  input wire logic [2:0] l1Ack,
  input wire logic [2:0] turnOffAck,
  input wire logic [2:0] l1Request_reg,
  input wire logic [8:0] linkState_reg,
  input wire logic [2:0] pmeMsg_reg,
  input wire logic deviceLowPower_reg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [7:0] reqCnt;
  // Age of a pending L1 request
  always @(posedge core_clk) begin
    if (srst || !l1Request_reg[0]) reqCnt <= 8'h0;
    else reqCnt <= reqCnt + 8'h1;
  end
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_answer_prompt: assert property ($rose(avs_read || avs_write) |-> ##[1:2] !avs_waitrequest)
    else $error("bus answer late");
  a_bus_response: assert property (!avs_waitrequest |->
    avs_response == ((avs_address > 4'ha) ? 2'h2 : 2'h0))
    else $error("bad response code");
  a_pme_down_only: assert property (!pmeMsg_reg[0])
    else $error("upstream pme");
  a_l1req_up_only: assert property (l1Request_reg[2:1] == 2'h0)
    else $error("downstream L1 request");
  a_port_c_l1: assert property (linkState_reg[8:7] != 2'h1)
    else $error("port C in L1");
  a_l1req_bounded: assert property (reqCnt <= 8'h66)
    else $error("L1 request never ends");
  a_l1_on_ack: assert property (l1Request_reg[0] && l1Ack[0] |->
    ##[1:5] linkState_reg[2:0] == 3'h3)
    else $error("acked L1 not entered");
  a_l23_after_ack: assert property ($rose(linkState_reg[2]) |->
    $past(turnOffAck[0], 2))
    else $error("L2/L3 without ack");
  a_low_power_acks: assert property ($rose(deviceLowPower_reg) |->
    &$past(turnOffAck, 2))
    else $error("low power without acks");
  c_l1: cover property (linkState_reg[2:0] == 3'h3);
  c_pme: cover property (pmeMsg_reg[1]);
  c_low: cover property (deviceLowPower_reg);
endmodule // sppm_checker
bind sppm_power_manager sppm_checker u_chk (.core_clk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_waitrequest, .avs_response, .l1Ack, .turnOffAck, .l1Request_reg,
  .linkState_reg, .pmeMsg_reg, .deviceLowPower_reg);
`default_nettype wire

// [bench/sppm_link_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module sppm_link_partner (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Link
  input wire logic [2:0] l1Request,
  input wire logic [7:0] ackDelay,
  input wire logic ackRefuse,
  output logic [2:0] l1Ack
);
  logic [7:0] waitCnt;
  always @(posedge core_clk) begin
    if (srst || !l1Request[0]) begin
      waitCnt <= 8'h0;
      l1Ack <= 3'h0;
    end else if (waitCnt == ackDelay) begin
      l1Ack <= {2'h0, !ackRefuse};
    end else begin
      waitCnt <= waitCnt + 8'h1;
    end
  end
endmodule // sppm_link_partner
`default_nettype wire

// [bench/test_sppm_power_manager.sv]
`timescale 1ns/1ps
`default_nettype none
module test_sppm_power_manager;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic [2:0] linkIdle = 3'h0, linkBusy = 3'h0, turnOffAck = 3'h0, l1Ack;
  logic [2:0] hotPlugEvent = 3'h0, pmeServiced = 3'h0, l1Request_reg, pmeMsg_reg;
  logic powerRemoved = 1'b0;
  logic [8:0] linkState_reg;
  logic deviceLowPower_reg;
  logic [7:0] ackDelay = 8'h1;
  logic ackRefuse = 1'b0;
  int err_total = 0, cmp_count = 0, cycleCnt = 0, pmeCnt = 0;
  logic [31:0] expQ[$];
  always #10 core_clk = ~core_clk;
  sppm_power_manager dut (.core_clk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .avs_response, .linkIdle, .linkBusy,
    .l1Ack, .turnOffAck, .powerRemoved, .hotPlugEvent, .pmeServiced, .l1Request_reg,
    .linkState_reg, .pmeMsg_reg, .deviceLowPower_reg);
  sppm_link_partner peer (.core_clk, .srst, .l1Request(l1Request_reg), .ackDelay,
    .ackRefuse, .l1Ack);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic test_done;
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Read notes its expected data; rw high writes d
  task automatic bus(input logic rw, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !rw;
    avs_write <= rw;
    if (!rw) expQ.push_back(d);
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic waitLs(input int p, input logic [2:0] v, input int lim);
    int n = 0;
    while (linkState_reg[p*3 +: 3] !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk("linkState", {29'h0, v}, {29'h0, linkState_reg[p*3 +: 3]});
  endtask
  always @(posedge core_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) chk("readdata", expQ.pop_front(), avs_readdata);
    // Unmapped offsets answer with the error code
    if ((avs_read || avs_write) && avs_waitrequest === 1'b0)
      chk("response", {30'h0, (avs_address > 4'ha) ? 2'h2 : 2'h0}, {30'h0, avs_response});
    if ((|pmeMsg_reg[2:1]) === 1'b1) pmeCnt++;
    cycleCnt++;
    if (cycleCnt == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    logic [7:0] t0;
    void'($urandom(32'h4371faf7));
    t0 = 8'h4 + 8'($urandom % 8);
    ackDelay <= 8'(1 + $urandom % 40);
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    bus(0, 4'h0, 32'h0);
    bus(0, 4'h6, 32'h1010);
    bus(0, 4'ha, 32'h400);
    bus(0, 4'hb, 32'h0);
    bus(1, 4'h8, 32'h7);
    for (int i = 0; i < 3; i++) bus(0, 4'(i), 32'h4);
    bus(1, 4'ha, 32'h10);
    bus(1, 4'h1, 32'h3);
    bus(0, 4'h1, 32'hb);
    bus(0, 4'h0, 32'h4);
    hotPlugEvent <= 3'h2;
    repeat (60) @(posedge core_clk);
    chk("pmeResend", 32'h1, 32'(pmeCnt > 1));
    hotPlugEvent <= 3'h0;
    pmeServiced <= 3'h2;
    repeat (8) @(posedge core_clk);
    pmeCnt = 0;
    repeat (60) @(posedge core_clk);
    chk("pmeStop", 32'h0, pmeCnt);
    pmeServiced <= 3'h0;
    bus(1, 4'h1, 32'h0);
    bus(0, 4'h1, 32'h0);
    bus(0, 4'ha, 32'h10);
    bus(1, 4'h6, {16'h0, 8'h20, t0});
    bus(1, 4'h3, 32'h3);
    bus(1, 4'h5, 32'h3);
    linkIdle <= 3'h5;
    waitLs(0, 3'h1, 40);
    waitLs(2, 3'h1, 40);
    waitLs(0, 3'h3, 120);
    // Mid-run reset, then an unanswered request
    srst <= 1'b1;
    ackRefuse <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    bus(1, 4'h6, {16'h0, 8'h20, t0});
    bus(1, 4'h3, 32'h2);
    waitLs(0, 3'h2, 80);
    waitLs(0, 3'h1, 120);
    ackRefuse <= 1'b0;
    linkIdle <= 3'h0;
    turnOffAck <= 3'h7;
    bus(1, 4'h8, 32'h7);
    bus(1, 4'h1, 32'h3);
    bus(1, 4'h0, 32'h3);
    waitLs(0, 3'h4, 20);
    repeat (4) @(posedge core_clk);
    chk("lowPower", 32'h1, {31'h0, deviceLowPower_reg});
    powerRemoved <= 1'b1;
    repeat (6) @(posedge core_clk);
    powerRemoved <= 1'b0;
    bus(0, 4'h1, 32'hf);
    // Port C in D3hot while the upstream port is cold
    bus(1, 4'h2, 32'h3);
    bus(0, 4'h2, 32'hb);
    pmeCnt = 0;
    hotPlugEvent <= 3'h6;
    repeat (60) @(posedge core_clk);
    chk("pmeCold", 32'h0, pmeCnt);
    test_done();
  end
endmodule // test_sppm_power_manager
`default_nettype wire

// [design/sppm_consts.vh]
`ifndef SPPM_CONSTS_VH
`define SPPM_CONSTS_VH
// Register word offsets
`define SPPM_OFF_PMCS_A 4'h0
`define SPPM_OFF_PMCS_B 4'h1
`define SPPM_OFF_PMCS_C 4'h2
`define SPPM_OFF_LCTL_A 4'h3
`define SPPM_OFF_LCTL_B 4'h4
`define SPPM_OFF_LCTL_C 4'h5
`define SPPM_OFF_VCTL 4'h6
`define SPPM_OFF_STATUS 4'h7
`define SPPM_OFF_CFGDONE 4'h8
`define SPPM_OFF_PME 4'h9
`define SPPM_OFF_PMETO 4'ha
// Power-state field encodings
`define SPPM_PS_D0 2'h0
`define SPPM_PS_D3HOT 2'h3
// Device power states
`define SPPM_DS_D0U 2'h0
`define SPPM_DS_D0A 2'h1
`define SPPM_DS_D3HOT 2'h2
`define SPPM_DS_D3COLD 2'h3
// Link states
`define SPPM_LS_L0 3'h0
`define SPPM_LS_L0S 3'h1
`define SPPM_LS_L1REQ 3'h2
`define SPPM_LS_L1 3'h3
`define SPPM_LS_L23 3'h4
// Field positions
`define SPPM_LCTL_L0S_BIT 0
`define SPPM_LCTL_L1_BIT 1
`define SPPM_VCTL_L0S_LSB 0
`define SPPM_VCTL_L1_LSB 8
// Reset values
`define SPPM_VCTL_RST 32'h0000_1010
`define SPPM_PMETO_RST 32'h0000_0400
// L1 request answer wait in cycles, then L0s
`define SPPM_L1ACK_CYC 8'h64
`endif

// [design/sppm_port_pm.v]
`timescale 1ns/1ps
`default_nettype none
`include "sppm_consts.vh"
module sppm_port_pm #(
  parameter L1OK = 1,
  parameter L1REQ = 0
) (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Control
  input wire [1:0] devState,
  input wire aspmL0sEn,
  input wire aspmL1En,
  input wire [7:0] l0sEntryTimer,
  input wire [7:0] l1EntryTimer,
  input wire linkIdle,
  input wire linkBusy,
  input wire l1Ack,
  input wire turnOffAck,
  // Status
  output reg [2:0] linkState_reg,
  output reg l1Request_reg
);
  reg [7:0] l0sCnt_reg;
  reg [7:0] l1Cnt_reg;
  reg [7:0] ackCnt_reg;
  reg [2:0] linkState_next;
  // Link states
  localparam [2:0] LS_L0 = 3'h0;
  localparam [2:0] LS_L0S = 3'h1;
  localparam [2:0] LS_L1REQ = 3'h2;
  localparam [2:0] LS_L1 = 3'h3;
  localparam [2:0] LS_L23 = 3'h4;
  wire d3 = (devState == `SPPM_DS_D3HOT);
  wire l1Allowed = (L1OK != 0) && (d3 || (aspmL1En && (L1REQ != 0)));
  // Downstream ports enter L1 without asking
  wire [2:0] l1Target = (L1REQ != 0) ? LS_L1REQ : LS_L1;
  always @(posedge core_clk) begin
    if (srst) begin
      l0sCnt_reg <= 8'h00;
      l1Cnt_reg <= 8'h00;
    end else begin
      if (!linkIdle || linkState_reg != LS_L0)
        l0sCnt_reg <= 8'h00;
      else if (l0sCnt_reg != 8'hff)
        l0sCnt_reg <= l0sCnt_reg + 8'h01;
      // Restart after a refused request, avoids a tight retry loop
      if (!linkIdle || linkState_reg == LS_L1REQ)
        l1Cnt_reg <= 8'h00;
      else if (l1Cnt_reg != 8'hff)
        l1Cnt_reg <= l1Cnt_reg + 8'h01;
    end
  end
  always @* begin
    linkState_next = linkState_reg;
    case (linkState_reg)
      LS_L0, LS_L0S: begin
        if (turnOffAck)
          linkState_next = LS_L23;
        else if (l1Allowed && linkIdle && (d3 || l1Cnt_reg >= l1EntryTimer))
          linkState_next = l1Target;
        else if (linkState_reg == LS_L0 && aspmL0sEn && linkIdle &&
                 l0sCnt_reg >= l0sEntryTimer)
          linkState_next = LS_L0S;
        else if (linkBusy)
          linkState_next = LS_L0;
      end
      LS_L1REQ: begin
        if (l1Ack)
          linkState_next = LS_L1;
        else if (ackCnt_reg == 8'h00)
          linkState_next = LS_L0S;
      end
      LS_L1: begin
        if (linkBusy && !d3)
          linkState_next = LS_L0;
      end
      LS_L23: begin
        // Left only through reset; no packets here
        linkState_next = LS_L23;
      end
      default: linkState_next = LS_L0;
    endcase
  end
  always @(posedge core_clk) begin
    if (srst) begin
      linkState_reg <= LS_L0;
      l1Request_reg <= 1'b0;
      ackCnt_reg <= 8'h00;
    end else begin
      linkState_reg <= linkState_next;
      l1Request_reg <= (linkState_next == LS_L1REQ);
      if (linkState_reg != LS_L1REQ)
        ackCnt_reg <= `SPPM_L1ACK_CYC;
      else if (ackCnt_reg != 8'h00)
        ackCnt_reg <= ackCnt_reg - 8'h01;
    end
  end
endmodule // sppm_port_pm
`default_nettype wire

// [design/sppm_power_manager.v]
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sppm_consts.vh"
module sppm_power_manager (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [1:0] avs_response,
  // Link side, ports A B C
  input wire [2:0] linkIdle,
  input wire [2:0] linkBusy,
  input wire [2:0] l1Ack,
  input wire [2:0] turnOffAck,
  input wire powerRemoved,
  input wire [2:0] hotPlugEvent,
  input wire [2:0] pmeServiced,
  output reg [2:0] l1Request_reg,
  output reg [8:0] linkState_reg,
  output reg [2:0] pmeMsg_reg,
  output reg deviceLowPower_reg
);
  reg [1:0] devState_reg [0:2];
  reg [1:0] psField_reg [0:2];
  reg [1:0] aspm_reg [0:2];
  reg [31:0] vctl_reg;
  reg [31:0] pmeTo_reg;
  reg [2:0] pmePend_reg;
  reg [31:0] pmeCnt_reg [0:2];
  reg pwrMeta_reg;
  reg pwrSync_reg;
  reg [2:0] hpMeta_reg;
  reg [2:0] hpSync_reg;
  reg [2:0] hpPrev_reg;
  reg [2:0] svMeta_reg;
  reg [2:0] svSync_reg;
  reg [2:0] idleMeta_reg, idleSync_reg, busyMeta_reg, busySync_reg;
  reg [2:0] ackMeta_reg, ackSync_reg, toMeta_reg, toSync_reg;
  reg accessDone_reg;
  wire [8:0] portLink;
  wire [2:0] portReq;
  wire access = (avs_read || avs_write) && !accessDone_reg;
  // Write lands only at the edge that sees waitrequest low
  wire wrHit = avs_write && !avs_waitrequest;
  integer i;
  integer j;
  // Pin inputs pass two flops
  always @(posedge core_clk) begin
    if (srst) begin
      pwrMeta_reg <= 1'b0;
      pwrSync_reg <= 1'b0;
      hpMeta_reg <= 3'h0;
      hpSync_reg <= 3'h0;
      svMeta_reg <= 3'h0;
      svSync_reg <= 3'h0;
      idleMeta_reg <= 3'h0;
      idleSync_reg <= 3'h0;
      busyMeta_reg <= 3'h0;
      busySync_reg <= 3'h0;
      ackMeta_reg <= 3'h0;
      ackSync_reg <= 3'h0;
      toMeta_reg <= 3'h0;
      toSync_reg <= 3'h0;
    end else begin
      pwrMeta_reg <= powerRemoved;
      pwrSync_reg <= pwrMeta_reg;
      hpMeta_reg <= hotPlugEvent;
      hpSync_reg <= hpMeta_reg;
      svMeta_reg <= pmeServiced;
      svSync_reg <= svMeta_reg;
      idleMeta_reg <= linkIdle;
      idleSync_reg <= idleMeta_reg;
      busyMeta_reg <= linkBusy;
      busySync_reg <= busyMeta_reg;
      ackMeta_reg <= l1Ack;
      ackSync_reg <= ackMeta_reg;
      toMeta_reg <= turnOffAck;
      toSync_reg <= toMeta_reg;
    end
  end
  // Bus slave: one wait cycle, answer on second edge
  always @(posedge core_clk) begin
    if (srst) begin
      accessDone_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else begin
      accessDone_reg <= access;
      avs_waitrequest <= !access;
      if (avs_read && !accessDone_reg) begin
        avs_response <= 2'h0;
        case (avs_address)
          `SPPM_OFF_PMCS_A: avs_readdata <= {28'h0, devState_reg[0], psField_reg[0]};
          `SPPM_OFF_PMCS_B: avs_readdata <= {28'h0, devState_reg[1], psField_reg[1]};
          `SPPM_OFF_PMCS_C: avs_readdata <= {28'h0, devState_reg[2], psField_reg[2]};
          `SPPM_OFF_LCTL_A: avs_readdata <= {30'h0, aspm_reg[0]};
          `SPPM_OFF_LCTL_B: avs_readdata <= {30'h0, aspm_reg[1]};
          `SPPM_OFF_LCTL_C: avs_readdata <= {30'h0, aspm_reg[2]};
          `SPPM_OFF_VCTL: avs_readdata <= vctl_reg;
          `SPPM_OFF_STATUS: avs_readdata <= {19'h0, deviceLowPower_reg, l1Request_reg,
                                             linkState_reg};
          `SPPM_OFF_PME: avs_readdata <= {29'h0, pmePend_reg};
          `SPPM_OFF_PMETO: avs_readdata <= pmeTo_reg;
          `SPPM_OFF_CFGDONE: avs_readdata <= 32'h0000_0000;
          default: begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h2;
          end
        endcase
      end else if (avs_write && !accessDone_reg) begin
        avs_response <= (avs_address > `SPPM_OFF_PMETO) ? 2'h2 : 2'h0;
      end
    end
  end
  // Control and power state registers
  always @(posedge core_clk) begin
    if (srst) begin
      vctl_reg <= `SPPM_VCTL_RST;
      pmeTo_reg <= `SPPM_PMETO_RST;
      deviceLowPower_reg <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
        devState_reg[i] <= `SPPM_DS_D0U;
        psField_reg[i] <= `SPPM_PS_D0;
        aspm_reg[i] <= 2'h0;
      end
    end else begin
      if (wrHit && avs_address == `SPPM_OFF_VCTL)
        vctl_reg <= avs_writedata;
      if (wrHit && avs_address == `SPPM_OFF_PMETO)
        pmeTo_reg <= avs_writedata;
      for (i = 0; i < 3; i = i + 1) begin
        if (wrHit && avs_address == `SPPM_OFF_LCTL_A + i[3:0])
          aspm_reg[i] <= avs_writedata[1:0];
        if (wrHit && avs_address == `SPPM_OFF_CFGDONE && avs_writedata[i] &&
            devState_reg[i] == `SPPM_DS_D0U)
          devState_reg[i] <= `SPPM_DS_D0A;
        if (wrHit && avs_address == `SPPM_OFF_PMCS_A + i[3:0]) begin
          psField_reg[i] <= avs_writedata[1:0];
          if (avs_writedata[1:0] == `SPPM_PS_D3HOT && devState_reg[i] == `SPPM_DS_D0A)
            devState_reg[i] <= `SPPM_DS_D3HOT;
          if (avs_writedata[1:0] == `SPPM_PS_D0 && devState_reg[i] == `SPPM_DS_D3HOT)
            devState_reg[i] <= `SPPM_DS_D0U;
        end
        if (pwrSync_reg && devState_reg[i] == `SPPM_DS_D3HOT)
          devState_reg[i] <= `SPPM_DS_D3COLD;
      end
      deviceLowPower_reg <= (devState_reg[0] == `SPPM_DS_D3HOT ||
                             devState_reg[0] == `SPPM_DS_D3COLD) &&
                            (&toSync_reg);
    end
  end
  // PME generation, downstream ports only
  always @(posedge core_clk) begin
    if (srst) begin
      pmePend_reg <= 3'h0;
      pmeMsg_reg <= 3'h0;
      hpPrev_reg <= 3'h0;
      for (j = 0; j < 3; j = j + 1)
        pmeCnt_reg[j] <= 32'h0;
    end else begin
      hpPrev_reg <= hpSync_reg;
      pmeMsg_reg[0] <= 1'b0;
      pmePend_reg[0] <= 1'b0;
      for (j = 1; j < 3; j = j + 1) begin
        pmeMsg_reg[j] <= 1'b0;
        if (devState_reg[j] == `SPPM_DS_D3COLD || devState_reg[0] == `SPPM_DS_D3COLD) begin
          pmePend_reg[j] <= 1'b0;
        end else if (hpSync_reg[j] && !hpPrev_reg[j] && (devState_reg[j] == `SPPM_DS_D3HOT ||
                     devState_reg[0] == `SPPM_DS_D3HOT)) begin
          pmePend_reg[j] <= 1'b1;
          pmeMsg_reg[j] <= 1'b1;
          pmeCnt_reg[j] <= pmeTo_reg;
        end else if (pmePend_reg[j]) begin
          if (svSync_reg[j]) begin
            pmePend_reg[j] <= 1'b0;
          end else if (pmeCnt_reg[j] == 32'h0) begin
            pmeMsg_reg[j] <= 1'b1;
            pmeCnt_reg[j] <= pmeTo_reg;
          end else begin
            pmeCnt_reg[j] <= pmeCnt_reg[j] - 32'h1;
          end
        end
      end
    end
  end
  // L1 ASPM on A only; B enters L1 only in D3hot, C never
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gPort
      sppm_port_pm #(
        .L1OK((g < 2) ? 1 : 0),
        .L1REQ((g == 0) ? 1 : 0)
      ) uPort (
        .core_clk(core_clk),
        .srst(srst),
        .devState(devState_reg[g]),
        .aspmL0sEn(aspm_reg[g][`SPPM_LCTL_L0S_BIT]),
        .aspmL1En(aspm_reg[g][`SPPM_LCTL_L1_BIT]),
        .l0sEntryTimer(vctl_reg[`SPPM_VCTL_L0S_LSB +: 8]),
        .l1EntryTimer(vctl_reg[`SPPM_VCTL_L1_LSB +: 8]),
        .linkIdle(idleSync_reg[g]),
        .linkBusy(busySync_reg[g]),
        .l1Ack(ackSync_reg[g]),
        .turnOffAck(toSync_reg[g]),
        .linkState_reg(portLink[3*g +: 3]),
        .l1Request_reg(portReq[g])
      );
    end
  endgenerate
  always @(posedge core_clk) begin
    if (srst) begin
      linkState_reg <= 9'h000;
      l1Request_reg <= 3'h0;
    end else begin
      linkState_reg <= portLink;
      l1Request_reg <= portReq;
    end
  end
endmodule // sppm_power_manager
`default_nettype wire
